// >>> core/imbss_pkg.sv
// Shared constants and types of the I2C master baud, stop and status block
package imbss_pkg;
  localparam logic [5:0] OFS_RELOAD  = 6'h00;
  localparam logic [5:0] OFS_BUFFER  = 6'h04;
  localparam logic [5:0] OFS_CTRL1   = 6'h08;
  localparam logic [5:0] OFS_SEQ     = 6'h0c;
  localparam logic [5:0] OFS_CTRL3   = 6'h10;
  localparam logic [5:0] OFS_STATUS  = 6'h14;
  localparam logic [5:0] OFS_MASK    = 6'h18;
  localparam logic [5:0] OFS_FLAGS1  = 6'h1c;
  localparam logic [5:0] OFS_FLAGS2  = 6'h20;
  localparam logic [5:0] OFS_IEN1    = 6'h24;
  localparam logic [5:0] OFS_IEN2    = 6'h28;
  localparam logic [7:0] REG_RESET   = 8'h00;
  localparam int         FLAG_BIT    = 3;
  localparam int         SEQ_START   = 0;
  localparam int         SEQ_RESTART = 1;
  localparam int         SEQ_STOP    = 2;
  localparam int         SEQ_RECV    = 3;
  localparam int         SEQ_ACK     = 4;
  localparam int         ST_SMP      = 7;
  localparam int         ST_CKE      = 6;
  localparam int         ST_DA       = 5;
  localparam int         ST_STOP     = 4;
  localparam int         ST_START    = 3;
  localparam int         ST_RW       = 2;
  localparam int         ST_UA       = 1;
  localparam int         ST_BF       = 0;
  localparam logic [3:0] MODE_I2C_MST = 4'h8;
  localparam logic [3:0] MODE_SPI_MST = 4'ha;
  localparam logic [2:0] BITS_LAST   = 3'h7;
  // Counter steps every second clock, so SCL = clock / (4 * (reload + 1))
  localparam int         BAUD_PRE_DIV  = 2;
  localparam logic       BAUD_PRE_LAST = 1'(BAUD_PRE_DIV - 1);

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_STOP_SDA,
    ST_STOP_SCL,
    ST_STOP_HOLD,
    ST_STOP_CHK,
    ST_START_SDA,
    ST_START_SCL,
    ST_START_HOLD,
    ST_START_LOW,
    ST_BIT_LOW,
    ST_BIT_HIGH,
    ST_ACK_LOW,
    ST_ACK_HIGH
  } imbss_fsm_t;
endpackage

// >>> core/imbss_baud.sv
// Baud counter: reloads from software value, pulses once per half period
`timescale 1ns/1ps
module imbss_baud
(
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic [7:0] reloadVal,
  input  wire logic       load,
  input  wire logic       run,
  output logic            expire
);
  import imbss_pkg::*;

  typedef struct packed {
    logic [7:0] count;
    logic       pre;
    logic       expire;
  } imbss_baud_reg_t;

  imbss_baud_reg_t q;
  imbss_baud_reg_t d;

  always_comb
  begin
    d = q;
    d.expire = 1'b0;
    if (load || !run)
    begin
      d.count = reloadVal;
      d.pre = 1'b0;
    end
    else if (q.pre == BAUD_PRE_LAST)
    begin
      d.pre = 1'b0;
      if (q.count == 8'h00)
      begin
        d.count = reloadVal;
        d.expire = 1'b1;
      end
      else
        d.count = q.count - 8'h01;
    end
    else
      d.pre = 1'b1;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      q <= '0;
    else
      q <= d;
  end

  assign expire = q.expire;
endmodule

// >>> core/imbss_top.sv
// I2C master stop sequence, baud pacing and status registers on AHB-Lite
//
// Local design decisions: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module imbss_top
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        sclIn,
  output logic             sclOut,
  output logic             sclOe,
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOe,
  output logic             slewCtrlEn,
  output logic             smbusLevels
);
  import imbss_pkg::*;

  typedef struct packed {
    imbss_fsm_t  state;
    logic [7:0]  reload;
    logic [7:0]  buffer;
    logic        wcol;
    logic        ov;
    logic        en;
    logic        ckp;
    logic [3:0]  mode;
    logic        gcen;
    logic        ackStat;
    logic        ackDt;
    logic [4:0]  req;
    logic [7:0]  ctrl3;
    logic [7:0]  mask;
    logic        input_phase_select;
    logic        cke;
    logic        dataAddr;
    logic        stopSeen;
    logic        startSeen;
    logic        rwSlave;
    logic        addrUpd;
    logic        bufFull;
    logic        txBusy;
    logic [7:0]  flags1;
    logic [7:0]  flags2;
    logic [7:0]  ien1;
    logic [7:0]  ien2;
    logic [7:0]  shift;
    logic        outBit;
    logic [2:0]  bitCnt;
    logic        rxMode;
    logic        ackOwn;
    logic        spiRun;
    logic        firstByte;
    logic        sclS1;
    logic        sclS2;
    logic        sclP;
    logic        sdaS1;
    logic        sdaS2;
    logic        sdaP;
    logic        sclOe;
    logic        sclOut;
    logic        sdaOe;
    logic        sdaOut;
    logic        slewEn;
    logic        smbus;
    logic [31:0] hrdata;
    logic        hready;
    logic        wrPend;
    logic [5:0]  wrAddr;
  } imbss_reg_t;

  localparam imbss_reg_t RESET_STATE = '{state: ST_IDLE, hready: 1'b1, default: '0};

  imbss_reg_t q;
  imbss_reg_t d;
  logic       expire;
  logic       baudLoad;
  logic       baudRun;
  logic       collide;
  logic       byteDone;
  logic       portEvent;
  logic       sampleNow;
  logic       changeNow;
  logic       idle;
  logic       i2cMst;
  logic       spiMst;
  logic       i2cMode;
  logic       startEv;
  logic       stopEv;
  logic [7:0] wdat;
  logic [7:0] rdVal;

  imbss_baud u_baud (
    .clock     (clock),
    .rst_n     (rst_n),
    .reloadVal (q.reload),
    .load      (baudLoad),
    .run       (baudRun),
    .expire    (expire)
  );

  always_comb
  begin
    d = q;
    collide = 1'b0;
    byteDone = 1'b0;
    portEvent = 1'b0;
    sampleNow = 1'b0;
    changeNow = 1'b0;
    wdat = hwdata[7:0];
    i2cMst = q.en && q.mode == MODE_I2C_MST;
    spiMst = q.en && q.mode == MODE_SPI_MST;
    i2cMode = q.mode inside {4'h6, 4'h7, 4'h8, 4'hb, 4'he, 4'hf};
    idle = q.state == ST_IDLE && q.req == 5'h00 && !q.txBusy && !q.spiRun;
    d.sclS1 = sclIn;
    d.sclS2 = q.sclS1;
    d.sclP = q.sclS2;
    d.sdaS1 = sdaIn;
    d.sdaS2 = q.sdaS1;
    d.sdaP = q.sdaS2;
    startEv = q.sclS2 && q.sclP && q.sdaP && !q.sdaS2;
    stopEv = q.sclS2 && q.sclP && !q.sdaP && q.sdaS2;
    // Read data is prepared in the address phase; zero wait states
    rdVal = 8'h00;
    unique case (haddr[5:0])
      OFS_RELOAD: rdVal = q.reload;
      OFS_BUFFER: rdVal = q.buffer;
      OFS_CTRL1:  rdVal = {q.wcol, q.ov, q.en, q.ckp, q.mode};
      OFS_SEQ:    rdVal = {q.gcen, q.ackStat, q.ackDt, q.req};
      OFS_CTRL3:  rdVal = q.ctrl3;
      OFS_STATUS:
      begin
        rdVal[ST_SMP] = q.input_phase_select;
        rdVal[ST_CKE] = q.cke;
        rdVal[ST_DA] = q.dataAddr;
        rdVal[ST_STOP] = q.stopSeen;
        rdVal[ST_START] = q.startSeen;
        rdVal[ST_RW] = (q.mode == MODE_I2C_MST) ? q.txBusy : q.rwSlave;
        rdVal[ST_UA] = q.addrUpd;
        rdVal[ST_BF] = q.bufFull;
      end
      OFS_MASK:   rdVal = q.mask;
      OFS_FLAGS1: rdVal = q.flags1;
      OFS_FLAGS2: rdVal = q.flags2;
      OFS_IEN1:   rdVal = q.ien1;
      OFS_IEN2:   rdVal = q.ien2;
      default:    rdVal = 8'h00;
    endcase
    d.wrPend = 1'b0;
    if (hsel && hready && htrans[1])
    begin
      d.wrPend = hwrite;
      d.wrAddr = haddr[5:0];
      if (!hwrite)
      begin
        d.hrdata = {24'h000000, rdVal};
        if (haddr[5:0] == OFS_BUFFER && !q.txBusy)
          d.bufFull = 1'b0;
      end
    end
    if (q.wrPend)
    begin
      unique case (q.wrAddr)
        OFS_RELOAD:
        begin
          d.reload = wdat;
          d.addrUpd = 1'b0;
        end
        OFS_BUFFER:
        begin
          if (!(i2cMst || spiMst))
            d.buffer = wdat;
          else if (idle)
          begin
            d.buffer = wdat;
            d.shift = wdat;
            d.outBit = wdat[7];
            d.bitCnt = BITS_LAST;
            d.rxMode = 1'b0;
            d.spiRun = spiMst;
            d.txBusy = i2cMst;
            d.bufFull = i2cMst | q.bufFull;
            d.sclOe = i2cMst;
            d.state = ST_BIT_LOW;
          end
          else
            d.wcol = 1'b1;
        end
        OFS_CTRL1:
        begin
          d.wcol = q.wcol & wdat[7];
          d.ov = q.ov & wdat[6];
          d.en = wdat[5];
          d.ckp = wdat[4];
          d.mode = wdat[3:0];
        end
        OFS_SEQ:
        begin
          d.gcen = wdat[7];
          d.ackDt = wdat[5];
          if (idle && i2cMst)
            d.req = wdat[4:0];
        end
        OFS_CTRL3:  d.ctrl3 = wdat;
        OFS_STATUS:
        begin
          d.input_phase_select = wdat[ST_SMP];
          d.cke = wdat[ST_CKE];
        end
        OFS_MASK:   d.mask = wdat;
        OFS_FLAGS1: d.flags1 = wdat;
        OFS_FLAGS2: d.flags2 = wdat;
        OFS_IEN1:   d.ien1 = wdat;
        OFS_IEN2:   d.ien2 = wdat;
        default:    d.ien2 = q.ien2;
      endcase
    end
    unique case (q.state)
      ST_IDLE:
        if (i2cMst)
        begin
          if (q.req[SEQ_STOP])
          begin
            d.sdaOe = 1'b1;
            d.sclOe = 1'b1;
            d.state = ST_STOP_SDA;
          end
          else if (q.req[SEQ_START] || q.req[SEQ_RESTART])
          begin
            d.sdaOe = 1'b0;
            d.state = ST_START_SDA;
          end
          else if (q.req[SEQ_ACK])
          begin
            d.sdaOe = !q.ackDt;
            d.sclOe = 1'b1;
            d.ackOwn = 1'b1;
            d.state = ST_ACK_LOW;
          end
          else if (q.req[SEQ_RECV])
          begin
            d.rxMode = 1'b1;
            d.outBit = 1'b1;
            d.bitCnt = BITS_LAST;
            d.sdaOe = 1'b0;
            d.sclOe = 1'b1;
            d.state = ST_BIT_LOW;
          end
        end
      ST_STOP_SDA:
        // Both lines must read low; a stale high SCL sample would look like a collision
        if (!q.sdaS2 && !q.sclS2)
        begin
          d.sclOe = 1'b0;
          d.state = ST_STOP_SCL;
        end
      ST_STOP_SCL:
        if (q.sclS2)
          d.state = ST_STOP_HOLD;
      ST_STOP_HOLD:
        if (!q.sclS2)
          collide = 1'b1;
        else if (expire)
        begin
          d.sdaOe = 1'b0;
          d.state = ST_STOP_CHK;
        end
      ST_STOP_CHK:
        if (!q.sclS2 && !q.sdaS2)
          collide = 1'b1;
        else if (expire)
        begin
          if (!q.sdaS2)
            collide = 1'b1;
          else
          begin
            d.req[SEQ_STOP] = 1'b0;
            portEvent = 1'b1;
            d.state = ST_IDLE;
          end
        end
      ST_START_SDA:
        if (expire)
        begin
          d.sclOe = 1'b0;
          d.state = ST_START_SCL;
        end
      ST_START_SCL:
        if (q.sclS2)
          d.state = ST_START_HOLD;
      ST_START_HOLD:
        if (!q.sdaS2 || !q.sclS2)
          collide = 1'b1;
        else if (expire)
        begin
          d.sdaOe = 1'b1;
          d.state = ST_START_LOW;
        end
      ST_START_LOW:
        if (expire)
        begin
          d.sclOe = 1'b1;
          d.req[SEQ_START] = 1'b0;
          d.req[SEQ_RESTART] = 1'b0;
          portEvent = 1'b1;
          d.state = ST_IDLE;
        end
      ST_BIT_LOW:
        if (expire)
        begin
          sampleNow = q.spiRun && !q.input_phase_select;
          changeNow = q.spiRun && !q.cke;
          d.sclOe = 1'b0;
          d.state = ST_BIT_HIGH;
        end
      ST_BIT_HIGH:
        if (expire)
        begin
          sampleNow = !q.spiRun || q.input_phase_select;
          changeNow = !q.spiRun || q.cke;
          d.sclOe = !q.spiRun;
          if (!q.spiRun && !q.rxMode && q.outBit && !q.sdaS2)
            collide = 1'b1;
          else if (q.bitCnt == 3'h0)
          begin
            byteDone = 1'b1;
            d.state = (q.spiRun || q.rxMode) ? ST_IDLE : ST_ACK_LOW;
          end
          else
          begin
            d.bitCnt = q.bitCnt - 3'h1;
            d.state = ST_BIT_LOW;
          end
        end
      ST_ACK_LOW:
        if (expire)
        begin
          d.sclOe = 1'b0;
          d.state = ST_ACK_HIGH;
        end
      ST_ACK_HIGH:
        if (q.ackOwn && q.ackDt && !q.sdaS2)
          collide = 1'b1;
        else if (expire)
        begin
          d.sclOe = 1'b1;
          if (q.ackOwn)
            d.req[SEQ_ACK] = 1'b0;
          else
            d.ackStat = q.sdaS2;
          d.txBusy = 1'b0;
          d.ackOwn = 1'b0;
          portEvent = 1'b1;
          d.state = ST_IDLE;
        end
    endcase
    if (sampleNow)
      d.shift = {q.shift[6:0], q.sdaS2};
    if (changeNow)
      d.outBit = d.shift[7];
    if (q.state == ST_BIT_LOW && !q.spiRun && !q.rxMode)
      d.sdaOe = !q.outBit;
    if (byteDone)
    begin
      d.dataAddr = !q.firstByte;
      d.firstByte = 1'b0;
      portEvent = 1'b1;
      if (q.spiRun || q.rxMode)
      begin
        if (q.bufFull)
          d.ov = 1'b1;
        else
          d.buffer = d.shift;
        d.bufFull = 1'b1;
        d.req[SEQ_RECV] = 1'b0;
        d.spiRun = 1'b0;
        d.outBit = 1'b1;
      end
      else
      begin
        d.bufFull = 1'b0;
        d.sdaOe = 1'b0;
      end
    end
    if (startEv)
    begin
      d.startSeen = 1'b1;
      d.stopSeen = 1'b0;
      d.firstByte = 1'b1;
      d.rwSlave = 1'b0;
    end
    if (stopEv)
    begin
      d.stopSeen = 1'b1;
      d.startSeen = 1'b0;
      d.rwSlave = 1'b0;
      portEvent = 1'b1;
    end
    if (collide)
    begin
      d.state = ST_IDLE;
      d.sclOe = 1'b0;
      d.sdaOe = 1'b0;
      d.req = 5'h00;
      d.ackOwn = 1'b0;
      if (q.txBusy)
        d.bufFull = 1'b0;
      d.txBusy = 1'b0;
      d.flags2[FLAG_BIT] = 1'b1;
    end
    if (portEvent)
      d.flags1[FLAG_BIT] = 1'b1;
    if (!q.en)
    begin
      d.state = ST_IDLE;
      d.startSeen = 1'b0;
      d.stopSeen = 1'b0;
      d.txBusy = 1'b0;
      d.spiRun = 1'b0;
      d.req = 5'h00;
      d.sclOe = 1'b0;
      d.sdaOe = 1'b0;
    end
    if (spiMst)
    begin
      d.sclOe = 1'b1;
      d.sdaOe = 1'b1;
      d.sclOut = d.state == ST_BIT_HIGH;
      d.sdaOut = d.outBit;
    end
    else
    begin
      d.sclOut = 1'b0;
      d.sdaOut = 1'b0;
    end
    d.slewEn = i2cMode && !q.input_phase_select;
    d.smbus = i2cMode && q.cke;
    d.hready = 1'b1;
    // Every step restarts the count; a stretched SCL holds it at reload
    baudLoad = d.state != q.state || (!q.sclS2 && q.state inside {ST_BIT_HIGH, ST_ACK_HIGH});
    baudRun = q.state != ST_IDLE;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      q <= RESET_STATE;
    else
      q <= d;
  end

  assign hrdata = q.hrdata;
  assign hreadyout = q.hready;
  assign hresp = 1'b0;
  assign sclOut = q.sclOut;
  assign sclOe = q.sclOe;
  assign sdaOut = q.sdaOut;
  assign sdaOe = q.sdaOe;
  assign slewCtrlEn = q.slewEn;
  assign smbusLevels = q.smbus;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  chk_stop_sda_coll: assert property (q.state == ST_STOP_CHK && q.sclS2 && expire && !q.sdaS2 && q.en
    |=> q.flags2[FLAG_BIT] && q.state == ST_IDLE) else $error("stop SDA low missed");
  chk_stop_scl_coll: assert property (q.state == ST_STOP_HOLD && !q.sclS2 && q.en
    |=> !q.sclOe && !q.sdaOe && !q.req[SEQ_STOP]) else $error("stop SCL low missed");
  chk_stop_begin: assert property (q.state == ST_IDLE && i2cMst && q.req[SEQ_STOP]
    |=> q.state == ST_STOP_SDA && q.sdaOe && q.sclOe) else $error("stop not begun");
  chk_stretch_wait: assert property (q.state == ST_STOP_SCL && !q.sclS2 && q.en
    |=> q.state == ST_STOP_SCL ##0 q.sdaOe) else $error("stretch not honoured");
  chk_buffer_start: assert property (q.wrPend && q.wrAddr == OFS_BUFFER && idle && i2cMst
    |=> q.state == ST_BIT_LOW && q.bufFull && q.txBusy) else $error("write did not start");
  chk_idle_hold: assert property (q.state == ST_IDLE && i2cMst && q.req == 5'h00 && !q.wrPend
    && $past(q.state) == ST_IDLE |=> $stable(q.sclOe)) else $error("SCL moved while idle");
  chk_bf_tx: assert property (byteDone && q.txBusy |=> !q.bufFull ##1 !q.bufFull)
    else $error("BF stuck after data bits");
  chk_idle_or: assert property (q.en && q.mode == MODE_I2C_MST && q.state != ST_IDLE
    |-> q.txBusy || q.req != 5'h00) else $error("busy not visible");
  chk_coll_release: assert property (collide |=> !q.sclOe && !q.sdaOe && q.req == 5'h00 && q.state == ST_IDLE)
    else $error("collision left lines driven");
  chk_seen_clear: assert property (!q.en |=> !q.startSeen && !q.stopSeen)
    else $error("seen flags not cleared");
  chk_data_addr: assert property (byteDone && q.firstByte && !startEv |=> !q.dataAddr)
    else $error("address byte marked data");

  cov_stop_done: cover property (q.state == ST_STOP_CHK ##1 q.state == ST_IDLE && q.flags1[FLAG_BIT]);
  cov_stop_coll: cover property (collide && q.state == ST_STOP_HOLD);
  cov_tx_byte: cover property (byteDone && q.txBusy);
  cov_rx_byte: cover property (byteDone && q.rxMode);
endmodule

// >>> verif/imbss_bus_model.sv
// Far-side I2C party: acknowledges bytes, stretches SCL, forces collisions
`timescale 1ns/1ps
module imbss_bus_model
(
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       sclWire,
  input  wire logic       sdaWire,
  input  wire logic       stretchReq,
  input  wire logic       sdaHold,
  input  wire logic       sclGlitch,
  output logic            sclLow,
  output logic            sdaLow,
  output logic [7:0]      rxByte
);
  logic       sclPrev_q;
  logic       sdaPrev_q;
  logic       ackPull_q;
  logic [3:0] bitCnt_q;
  logic [5:0] stretchCnt_q;
  logic [2:0] highCnt_q;
  logic [2:0] glitchCnt_q;
  assign sdaLow = ackPull_q | sdaHold;
  assign sclLow = (stretchCnt_q != 6'h00) | (glitchCnt_q != 3'h0);
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sclPrev_q <= 1'b1;
      sdaPrev_q <= 1'b1;
      ackPull_q <= 1'b0;
      bitCnt_q <= 4'h0;
      stretchCnt_q <= 6'h00;
      highCnt_q <= 3'h0;
      glitchCnt_q <= 3'h0;
      rxByte <= 8'h00;
    end
    else
    begin
      sclPrev_q <= sclWire;
      sdaPrev_q <= sdaWire;
      if (sclWire && !sclPrev_q && bitCnt_q < 4'h8)
        rxByte <= {rxByte[6:0], sdaWire};
      if (sclWire && sclPrev_q && sdaWire && !sdaPrev_q)
        bitCnt_q <= 4'h0;
      else if (sclWire && !sclPrev_q)
        bitCnt_q <= (bitCnt_q == 4'h8) ? 4'h0 : bitCnt_q + 4'h1;
      // Acknowledge from the 8th falling edge to the 9th
      if (bitCnt_q == 4'h8 && !sclWire)
        ackPull_q <= 1'b1;
      else if (!sclWire && sclPrev_q)
        ackPull_q <= 1'b0;
      if (stretchReq)
        stretchCnt_q <= 6'h28;
      else if (stretchCnt_q != 6'h00)
        stretchCnt_q <= stretchCnt_q - 6'h01;
      highCnt_q <= (sclWire && !sdaWire && highCnt_q != 3'h7) ? highCnt_q + 3'h1 : 3'h0;
      if (sclGlitch && highCnt_q == 3'h3)
        glitchCnt_q <= 3'h4;
      else if (glitchCnt_q != 3'h0)
        glitchCnt_q <= glitchCnt_q - 3'h1;
    end
  end
endmodule

// >>> verif/tb_top.sv
// Testbench: registers, transmit, stop sequences and collisions
`timescale 1ns/1ps
module tb_top;
  import imbss_pkg::*;
  logic        clock, rst_n, hsel, hwrite, hreadyout, hresp, stretchReq, sdaHold, sclGlitch;
  logic        sclOut, sclOe, sdaOut, sdaOe, slewCtrlEn, smbusLevels, sclLow, sdaLow;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  rxByte, sv;
  int          fails, check_count, cycles;
  wire sclWire = ~((sclOe & ~sclOut) | sclLow);
  wire sdaWire = ~((sdaOe & ~sdaOut) | sdaLow);
  imbss_top i_dut (.clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .sclIn(sclWire), .sclOut(sclOut), .sclOe(sclOe),
    .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe), .slewCtrlEn(slewCtrlEn), .smbusLevels(smbusLevels));
  imbss_bus_model i_bus (.clock(clock), .rst_n(rst_n), .sclWire(sclWire), .sdaWire(sdaWire),
    .stretchReq(stretchReq), .sdaHold(sdaHold), .sclGlitch(sclGlitch), .sclLow(sclLow),
    .sdaLow(sdaLow), .rxByte(rxByte));
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic end_sim;
    if (fails == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 50000)
    begin
      fails++;
      end_sim();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] wd, output logic [7:0] r);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= {26'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    do @(posedge clock); while (hreadyout !== 1'b1);
    r = hrdata[7:0];
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] x;
    bus(1'b1, a, d, x);
  endtask
  task automatic rdchk(input logic [5:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] x;
    bus(1'b0, a, 8'h00, x);
    chk(x & m, e);
  endtask
  task automatic waitBit(input logic [5:0] a);
    logic [7:0] x;
    x = 8'h00;
    for (int i = 0; i < 3000 && x[FLAG_BIT] !== 1'b1; i++)
      bus(1'b0, a, 8'h00, x);
  endtask
  task automatic txByte(input logic [7:0] r, input logic [7:0] d, input logic dataByte);
    int n;
    wr(OFS_FLAGS1, 8'h00);
    wr(OFS_RELOAD, r);
    wr(OFS_BUFFER, d);
    rdchk(OFS_STATUS, 8'h05, 8'h05);
    wr(OFS_BUFFER, ~d);
    rdchk(OFS_CTRL1, 8'h80, 8'h80);
    wr(OFS_CTRL1, 8'h28);
    while (sclOe !== 1'b1) @(posedge clock);
    while (sclOe !== 1'b0) @(posedge clock);
    n = 0;
    while (sclOe === 1'b0 && n < 999)
    begin
      @(posedge clock);
      n++;
    end
    chk({7'h0, n >= 2 * (r + 1) && n <= 2 * (r + 1) + 4}, 8'h01);
    waitBit(OFS_FLAGS1);
    // Flag rises after the eighth bit; let the acknowledge clock finish
    repeat (4 * r + 24) @(posedge clock);
    rdchk(OFS_STATUS, 8'h25, {2'h0, dataByte, 5'h00});
    rdchk(OFS_SEQ, 8'h40, 8'h00);
    chk(rxByte, d);
    repeat (10) @(posedge clock);
    chk({7'h0, sclOe}, 8'h01);
  endtask
  task automatic stopSeq(input logic s, input logic c);
    wr(OFS_FLAGS1, 8'h00);
    stretchReq <= s;
    wr(OFS_SEQ, 8'h04);
    stretchReq <= 1'b0;
    waitBit(c ? OFS_FLAGS2 : OFS_FLAGS1);
    // Bus stop shows before the closing count runs out
    repeat (64) @(posedge clock);
    rdchk(OFS_FLAGS2, 8'h08, {4'h0, c, 3'h0});
    rdchk(OFS_SEQ, 8'h1f, 8'h00);
    rdchk(OFS_STATUS, c ? 8'h04 : 8'h14, c ? 8'h00 : 8'h10);
    chk({6'h0, sclOe, sdaOe}, 8'h00);
    wr(OFS_FLAGS2, 8'h00);
  endtask
  initial
  begin
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    stretchReq = 1'b0;
    sdaHold = 1'b0;
    sclGlitch = 1'b0;
    fails = 0;
    check_count = 0;
    cycles = 0;
    void'($urandom(12450));
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    repeat (2) @(posedge clock);
    for (int a = 0; a <= 8'h2c; a += 4)
      rdchk(6'(a), 8'hff, REG_RESET);
    chk({7'h0, hresp}, 8'h00);
    wr(OFS_CTRL1, 8'h28);
    for (int i = 0; i < 3; i++)
    begin
      sv = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
      wr(OFS_STATUS, sv);
      rdchk(OFS_STATUS, 8'hff, sv & 8'hc0);
      repeat (2) @(posedge clock);
      chk({6'h0, slewCtrlEn, smbusLevels}, {6'h0, ~sv[7], sv[6]});
    end
    wr(OFS_CTRL1, 8'h2a);
    repeat (2) @(posedge clock);
    chk({7'h0, smbusLevels}, 8'h00);
    wr(OFS_CTRL1, 8'h28);
    wr(OFS_STATUS, 8'h00);
    txByte(8'h03, 8'ha5, 1'b1);
    stopSeq(1'b1, 1'b0);
    wr(OFS_CTRL1, 8'h08);
    rdchk(OFS_STATUS, 8'h18, 8'h00);
    wr(OFS_CTRL1, 8'h28);
    sdaHold <= 1'b1;
    repeat (4) @(posedge clock);
    rdchk(OFS_STATUS, 8'h18, 8'h08);
    sdaHold <= 1'b0;
    repeat (4) @(posedge clock);
    rdchk(OFS_STATUS, 8'h18, 8'h10);
    txByte(8'($urandom_range(10, 3)), 8'($urandom), 1'b0);
    wr(OFS_FLAGS1, 8'h00);
    wr(OFS_SEQ, 8'h08);
    waitBit(OFS_FLAGS1);
    rdchk(OFS_STATUS, 8'h01, 8'h01);
    rdchk(OFS_BUFFER, 8'hff, 8'hff);
    rdchk(OFS_STATUS, 8'h01, 8'h00);
    wr(OFS_FLAGS1, 8'h00);
    wr(OFS_SEQ, 8'h10);
    waitBit(OFS_FLAGS1);
    rdchk(OFS_SEQ, 8'h1f, 8'h00);
    stopSeq(1'b0, 1'b0);
    wr(OFS_RELOAD, 8'h03);
    sdaHold <= 1'b1;
    stopSeq(1'b0, 1'b1);
    sdaHold <= 1'b0;
    sclGlitch <= 1'b1;
    stopSeq(1'b0, 1'b1);
    sclGlitch <= 1'b0;
    end_sim();
  end
endmodule
